//--- hw/pq_irq_pkg.sv
// constants, register map and carrier types for the secondary interrupt enable block
package pq_irq_pkg;
    localparam int unsigned REG_ADDR_W = 16;
    localparam int unsigned REG_DATA_W = 32;
    // register map, word addresses on the host register port
    localparam logic [15:0] IRQ_ENABLE_ADDR = 16'h0406;
    localparam logic [15:0] IRQ_STATUS_ADDR = 16'h0403;
    localparam logic [15:0] CHECKSUM_ADDR = 16'h0420;
    localparam logic [15:0] SETUP3_ADDR = 16'h0421;
    // reset values
    localparam logic [31:0] IRQ_ENABLE_RST = 32'h0000_0000;
    localparam logic [31:0] CHECKSUM_RST = 32'h0000_0000;
    localparam logic [3:0] OC_SELECT_RST = 4'h0;
    // bit positions
    localparam int unsigned FAULT_ZERO_BIT = 28;
    localparam int unsigned FAULT_ONE_BIT = 29;
    localparam int unsigned FAULT_TWO_BIT = 30;
    localparam int unsigned FAULT_THREE_BIT = 31;
    localparam int unsigned CRC_DONE_BIT = 27;
    localparam int unsigned CRC_CHANGED_BIT = 26;
    localparam int unsigned SAG_A_BIT = 23;
    localparam int unsigned SURGE_A_BIT = 20;
    localparam int unsigned PHASE_ORDER_BIT = 18;
    localparam int unsigned OVERCURRENT_BIT = 17;
    localparam int unsigned CURRENT_ZX_A_BIT = 13;
    localparam int unsigned MERGED_ZX_BIT = 12;
    localparam int unsigned VOLTAGE_ZX_A_BIT = 9;
    localparam int unsigned OC_SELECT_LSB = 0;
    localparam int unsigned OC_SELECT_W = 4;
    // bits implemented in this group; reserved 19 and 16 and the lower group read zero
    localparam logic [31:0] IMPL_BITS = 32'hFFF6_FE00;
    // errors that never gate on the mask
    localparam logic [31:0] UNMASKABLE_BITS = 32'h3000_0000;
    // errors held until a reset of either kind
    localparam logic [31:0] RESET_ONLY_BITS = 32'hB000_0000;

    typedef enum logic [1:0] {
        CRC_IDLE = 2'b01,
        CRC_WAIT = 2'b10
    } crc_state_type;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [31:0] wdata;
    } reg_req_type;

    typedef struct packed {
        logic [3:0] fault;
        logic crc_force;
        logic crc_done;
        logic crc_changed;
        logic [31:0] crc_value;
        logic [2:0] sag_level;
        logic [2:0] surge_level;
        logic phase_order_fault;
        logic [3:0] overcurrent;
        logic [2:0] current_zx;
        logic merged_zx;
        logic [2:0] voltage_zx;
    } monitor_events_type;
endpackage : pq_irq_pkg

//--- hw/sticky_flags.sv
// sticky status flags: hardware set, software write-one clear, reset-only bits
`timescale 1ns/1ps
module sticky_flags import pq_irq_pkg::*; #(
    parameter int unsigned WIDTH = 32,
    parameter logic [31:0] HOLD_BITS = RESET_ONLY_BITS
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic sw_reset,
    input wire logic [WIDTH-1:0] set_bits,
    input wire logic [WIDTH-1:0] clear_bits,
    output logic [WIDTH-1:0] flags
);
    logic [WIDTH-1:0] flags_q;
    logic [WIDTH-1:0] flags_d;
    wire logic [WIDTH-1:0] clear_ok = clear_bits & ~HOLD_BITS[WIDTH-1:0];

    // set beats a clear landing in the same cycle
    assign flags_d = (flags_q & ~clear_ok) | set_bits;
    assign flags = flags_q;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            flags_q <= '0;
        end else if (sw_reset) begin
            flags_q <= '0;
        end else begin
            flags_q <= flags_d;
        end
    end

    chk_set_wins: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (!sw_reset && set_bits != '0) |=> ((flags_q & $past(set_bits)) == $past(set_bits)))
        else $error("set flag lost");
endmodule : sticky_flags

//--- hw/power_monitor_irq_mask.sv
// secondary interrupt enable register with its status flags and interrupt pin
// Operation
// - fault three interrupts only with mask bit 31; held until reset.
// - fault two interrupts only when mask bit 30 is one.
// - faults one and zero always interrupt; cleared only by reset.
// - bit 27 enables interrupt when a forced checksum computation finishes.
// - bit 26 enables interrupt on checksum change; result register takes new value.
// - bits 25..23 enable interrupt when phase C, B, A enters sag.
// - bits 22..20 enable interrupt when phase C, B, A enters surge.
// - bit 18 enables interrupt on a phase order fault.
// - bit 17 enables interrupt on overcurrent of any selected current channel.
// - bits 15..13 enable interrupt on phase C, B, A current zero crossing.
// - bit 12 enables interrupt on merged voltage zero crossing.
// - bits 11..9 enable interrupt on phase C, B, A voltage zero crossing.
`timescale 1ns/1ps
module power_monitor_irq_mask import pq_irq_pkg::*; (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic sw_reset,
    input wire reg_req_type reg_req,
    input wire monitor_events_type events,
    output logic [31:0] reg_rdata,
    output logic reg_rvalid,
    output logic [31:0] checksum_value_reg,
    output logic irq_n
);
    function automatic logic addr_hit(input logic [15:0] addr, input logic [15:0] target);
        addr_hit = (addr == target);
    endfunction : addr_hit

    logic [31:0] secondary_interrupt_enable_q;
    logic [3:0] overcurrent_channel_select_q;
    logic [31:0] checksum_q;
    logic [2:0] sag_prev_q;
    logic [2:0] surge_prev_q;
    crc_state_type crc_state_q;
    crc_state_type crc_state_d;
    logic [31:0] rdata_q;
    logic rvalid_q;
    logic irq_n_q;
    logic [31:0] status;

    wire logic hit_enable = addr_hit(reg_req.addr, IRQ_ENABLE_ADDR);
    wire logic hit_status = addr_hit(reg_req.addr, IRQ_STATUS_ADDR);
    wire logic hit_checksum = addr_hit(reg_req.addr, CHECKSUM_ADDR);
    wire logic hit_setup3 = addr_hit(reg_req.addr, SETUP3_ADDR);
    wire logic wr_enable = reg_req.wr && hit_enable;
    wire logic wr_setup3 = reg_req.wr && hit_setup3;
    wire logic [31:0] clear_bits = (reg_req.wr && hit_status) ? reg_req.wdata : 32'h0000_0000;

    // only a done that follows a forced request counts
    wire logic crc_done_ok = events.crc_done && (crc_state_q == CRC_WAIT);
    wire logic [2:0] sag_enter = events.sag_level & ~sag_prev_q;
    wire logic [2:0] surge_enter = events.surge_level & ~surge_prev_q;
    wire logic oc_hit = |(events.overcurrent & overcurrent_channel_select_q);

    logic [31:0] set_bits;
    always_comb begin
        set_bits = 32'h0000_0000;
        set_bits[FAULT_THREE_BIT] = events.fault[3];
        set_bits[FAULT_TWO_BIT] = events.fault[2];
        set_bits[FAULT_ONE_BIT] = events.fault[1];
        set_bits[FAULT_ZERO_BIT] = events.fault[0];
        set_bits[CRC_DONE_BIT] = crc_done_ok;
        set_bits[CRC_CHANGED_BIT] = events.crc_changed;
        set_bits[SAG_A_BIT +: 3] = sag_enter;
        set_bits[SURGE_A_BIT +: 3] = surge_enter;
        set_bits[PHASE_ORDER_BIT] = events.phase_order_fault;
        set_bits[OVERCURRENT_BIT] = oc_hit;
        set_bits[CURRENT_ZX_A_BIT +: 3] = events.current_zx;
        set_bits[MERGED_ZX_BIT] = events.merged_zx;
        set_bits[VOLTAGE_ZX_A_BIT +: 3] = events.voltage_zx;
    end

    sticky_flags #(
        .WIDTH(32),
        .HOLD_BITS(RESET_ONLY_BITS)
    ) u_flags (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .sw_reset(sw_reset),
        .set_bits(set_bits),
        .clear_bits(clear_bits),
        .flags(status)
    );

    // mask bits 29 and 28 are stored but gate nothing
    wire logic [31:0] pending = status & (secondary_interrupt_enable_q | UNMASKABLE_BITS);

    always_comb begin
        crc_state_d = crc_state_q;
        case (crc_state_q)
            CRC_IDLE: begin
                if (events.crc_force) begin
                    crc_state_d = CRC_WAIT;
                end
            end
            CRC_WAIT: begin
                if (events.crc_done) begin
                    crc_state_d = CRC_IDLE;
                end
            end
            default: begin
                crc_state_d = CRC_IDLE;
            end
        endcase
    end

    wire logic [31:0] read_mux =
        hit_enable ? secondary_interrupt_enable_q :
        hit_status ? (status & IMPL_BITS) :
        hit_checksum ? checksum_q :
        hit_setup3 ? {28'h000_0000, overcurrent_channel_select_q} :
        32'h0000_0000;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            secondary_interrupt_enable_q <= IRQ_ENABLE_RST;
            overcurrent_channel_select_q <= OC_SELECT_RST;
            checksum_q <= CHECKSUM_RST;
            crc_state_q <= CRC_IDLE;
            sag_prev_q <= 3'h0;
            surge_prev_q <= 3'h0;
            rdata_q <= 32'h0000_0000;
            rvalid_q <= 1'b0;
            irq_n_q <= 1'b1;
        end else if (sw_reset) begin
            secondary_interrupt_enable_q <= IRQ_ENABLE_RST;
            overcurrent_channel_select_q <= OC_SELECT_RST;
            checksum_q <= CHECKSUM_RST;
            crc_state_q <= CRC_IDLE;
            sag_prev_q <= events.sag_level;
            surge_prev_q <= events.surge_level;
            rdata_q <= 32'h0000_0000;
            rvalid_q <= 1'b0;
            irq_n_q <= 1'b1;
        end else begin
            if (wr_enable) begin
                // reserved bits never store, so they read zero
                secondary_interrupt_enable_q <= reg_req.wdata & IMPL_BITS;
            end
            if (wr_setup3) begin
                overcurrent_channel_select_q <= reg_req.wdata[OC_SELECT_LSB +: OC_SELECT_W];
            end
            if (events.crc_changed) begin
                checksum_q <= events.crc_value;
            end
            crc_state_q <= crc_state_d;
            sag_prev_q <= events.sag_level;
            surge_prev_q <= events.surge_level;
            rdata_q <= reg_req.rd ? read_mux : rdata_q;
            rvalid_q <= reg_req.rd;
            irq_n_q <= ~|pending;
        end
    end

    assign reg_rdata = rdata_q;
    assign reg_rvalid = rvalid_q;
    assign checksum_value_reg = checksum_q;
    assign irq_n = irq_n_q;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    sequence fault3_seen;
        !sw_reset && events.fault[3];
    endsequence
    chk_fault_three_hold: assert property (fault3_seen ##1 !sw_reset [*4] |-> status[31])
        else $error("fault three flag cleared without reset");
    chk_fault_two_gate: assert property (!sw_reset && status == 32'h4000_0000
        |=> irq_n == !$past(secondary_interrupt_enable_q[30]))
        else $error("fault two not gated by mask");
    chk_fault_unmasked: assert property ((status[29] || status[28]) && !sw_reset
        |=> !irq_n && (status[29] || status[28] || $past(sw_reset)))
        else $error("unmaskable fault not signalled");
    sequence crc_forced;
        crc_state_q == CRC_IDLE && events.crc_force && !sw_reset;
    endsequence
    chk_crc_done_flag: assert property (crc_forced ##1 (!events.crc_done && !sw_reset)
        ##1 (events.crc_done && !sw_reset) |=> status[27])
        else $error("forced checksum completion missed");
    chk_checksum_load: assert property (events.crc_changed && !sw_reset
        |=> checksum_value_reg == $past(events.crc_value) && status[26])
        else $error("checksum result not loaded");
    chk_sag_entry: assert property (events.sag_level[0] && !sag_prev_q[0] && !sw_reset
        |=> status[23])
        else $error("phase a sag entry missed");
    chk_surge_entry: assert property (events.surge_level[2] && !surge_prev_q[2]
        && !sw_reset |=> status[22])
        else $error("phase c surge entry missed");
    chk_phase_order: assert property (events.phase_order_fault && !sw_reset
        |=> status[18])
        else $error("phase order fault missed");
    chk_overcurrent_sel: assert property (!sw_reset && !status[17]
        && (events.overcurrent & overcurrent_channel_select_q) == 4'h0 |=> !status[17])
        else $error("unselected overcurrent flagged");
    chk_current_zx: assert property (events.current_zx[1] && !sw_reset
        |=> status[14])
        else $error("phase b current crossing missed");
    chk_merged_zx: assert property (events.merged_zx && !sw_reset |=> status[12])
        else $error("merged crossing missed");
    chk_voltage_zx: assert property (events.voltage_zx[0] && !sw_reset
        ##1 (secondary_interrupt_enable_q[9] && !sw_reset) |=> !irq_n)
        else $error("phase a voltage crossing not signalled");
    chk_reserved_zero: assert property (reg_req.rd && hit_enable && !sw_reset
        |=> reg_rvalid && reg_rdata[19] == 1'b0 && reg_rdata[16] == 1'b0)
        else $error("reserved bits read nonzero");
endmodule : power_monitor_irq_mask

//--- verification/host_model.sv
// host side model: register port master that also reads back the result
`timescale 1ns/1ps
module host_model import pq_irq_pkg::*; (
    input wire logic sys_clk,
    input wire logic [31:0] reg_rdata,
    input wire logic reg_rvalid,
    output reg_req_type reg_req
);
    initial reg_req = '0;

    // strobes last one cycle and are dropped after the taking edge
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        #1 reg_req = '{wr: 1'h1, rd: 1'h0, addr: a, wdata: d};
        @(posedge sys_clk);
        #1 reg_req = '0;
    endtask : wr

    // a missing valid pulse hands back unknown so the caller's compare fails
    task automatic rd(input logic [15:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        #1 reg_req = '{wr: 1'h0, rd: 1'h1, addr: a, wdata: 32'h0000_0000};
        @(posedge sys_clk);
        #1 reg_req = '0;
        d = (reg_rvalid === 1'h1) ? reg_rdata : 'x;
    endtask : rd
endmodule : host_model

//--- verification/test_power_monitor_irq_mask.sv
// self-checking bench for the secondary interrupt enable block
`timescale 1ns/1ps
module test_power_monitor_irq_mask import pq_irq_pkg::*;;
    logic sys_clk;
    logic rst_n;
    logic sw_reset;
    reg_req_type reg_req;
    monitor_events_type ev;
    logic [31:0] reg_rdata;
    logic reg_rvalid;
    logic [31:0] checksum_value_reg;
    logic irq_n;
    int bad_count;
    int samples_checked;
    int srcs[18] = '{30, 27, 26, 25, 24, 23, 22, 21, 20, 18, 17, 15, 14, 13, 12, 11, 10, 9};

    power_monitor_irq_mask u_power_monitor_irq_mask (.sys_clk(sys_clk), .rst_n(rst_n),
        .sw_reset(sw_reset), .reg_req(reg_req), .events(ev), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .checksum_value_reg(checksum_value_reg), .irq_n(irq_n));
    host_model u_host_model (.sys_clk(sys_clk), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .reg_req(reg_req));

    initial begin
        sys_clk = 1'h0;
        forever #2 sys_clk = ~sys_clk;
    end

    task automatic end_sim;
        $display("checks %0d errors %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_sim

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic rchk(input string what, input logic [15:0] a, input logic [31:0] exp);
        logic [31:0] d;
        u_host_model.rd(a, d);
        check(what, exp, d);
    endtask : rchk

    // the interrupt takes one edge to follow its flag
    task automatic irq_is(input logic v);
        for (int i = 0; i < 4 && irq_n !== v; i++) begin
            @(posedge sys_clk);
            #1;
        end
        check("irq_n", {31'h0, v}, {31'h0, irq_n});
        if (irq_n !== v) end_sim();
    endtask : irq_is

    task automatic drive(input monitor_events_type e);
        @(posedge sys_clk);
        #1 ev = e;
        @(posedge sys_clk);
        #1 ev = '0;
    endtask : drive

    // one event for status bit b; a finished checksum is preceded by its request
    task automatic pulse(input int b);
        monitor_events_type e;
        e = '0;
        e.crc_value = 32'h5A3C_96E1;
        case (b)
            31, 30, 29, 28: e.fault[b-28] = 1'h1;
            27: e.crc_done = 1'h1;
            26: e.crc_changed = 1'h1;
            25, 24, 23: e.sag_level[b-23] = 1'h1;
            22, 21, 20: e.surge_level[b-20] = 1'h1;
            18: e.phase_order_fault = 1'h1;
            17: e.overcurrent = 4'h8;
            15, 14, 13: e.current_zx[b-13] = 1'h1;
            12: e.merged_zx = 1'h1;
            default: e.voltage_zx[b-9] = 1'h1;
        endcase
        if (b == 27) drive('{crc_force: 1'h1, default: '0});
        drive(e);
    endtask : pulse

    task automatic s_reset_map;
        rchk("mask", IRQ_ENABLE_ADDR, 32'h0000_0000);
        rchk("status", IRQ_STATUS_ADDR, 32'h0000_0000);
        check("checksum", 32'h0000_0000, checksum_value_reg);
        rchk("unmapped", 16'h0500, 32'h0000_0000);
        u_host_model.wr(IRQ_ENABLE_ADDR, 32'hFFFF_FFFF);
        rchk("mask", IRQ_ENABLE_ADDR, 32'hFFF6_FE00);
        u_host_model.wr(IRQ_ENABLE_ADDR, 32'h0000_0000);
    endtask : s_reset_map

    // each maskable source but fault three raises the pin when enabled and only sets its flag when not
    task automatic s_sources;
        u_host_model.wr(SETUP3_ADDR, 32'h0000_0008);
        rchk("oc select", SETUP3_ADDR, 32'h0000_0008);
        foreach (srcs[i]) begin
            u_host_model.wr(IRQ_ENABLE_ADDR, 32'h1 << srcs[i]);
            pulse(srcs[i]);
            irq_is(1'h0);
            rchk("status", IRQ_STATUS_ADDR, 32'h1 << srcs[i]);
            u_host_model.wr(IRQ_STATUS_ADDR, 32'h1 << srcs[i]);
            irq_is(1'h1);
            u_host_model.wr(IRQ_ENABLE_ADDR, 32'h0000_0000);
            pulse(srcs[i]);
            repeat (4) @(posedge sys_clk);
            irq_is(1'h1);
            rchk("status", IRQ_STATUS_ADDR, 32'h1 << srcs[i]);
            u_host_model.wr(IRQ_STATUS_ADDR, 32'h1 << srcs[i]);
        end
        check("checksum", 32'h5A3C_96E1, checksum_value_reg);
        rchk("checksum", CHECKSUM_ADDR, 32'h5A3C_96E1);
    endtask : s_sources

    // unrequested checksum completion and unselected channels must not flag
    task automatic s_refused;
        u_host_model.wr(IRQ_ENABLE_ADDR, 32'h0802_0000);
        drive('{crc_done: 1'h1, overcurrent: 4'h7, default: '0});
        repeat (4) @(posedge sys_clk);
        irq_is(1'h1);
        rchk("status", IRQ_STATUS_ADDR, 32'h0000_0000);
        // a sag level that stays high must not flag again once cleared
        @(posedge sys_clk);
        #1 ev.sag_level = 3'h1;
        u_host_model.wr(IRQ_STATUS_ADDR, 32'hFFFF_FFFF);
        rchk("status", IRQ_STATUS_ADDR, 32'h0000_0000);
        ev = '0;
    endtask : s_refused

    task automatic s_faults;
        u_host_model.wr(IRQ_ENABLE_ADDR, 32'h0000_0000);
        pulse(31);
        repeat (4) @(posedge sys_clk);
        irq_is(1'h1);
        u_host_model.wr(IRQ_ENABLE_ADDR, 32'h8000_0000);
        irq_is(1'h0);
        u_host_model.wr(IRQ_STATUS_ADDR, 32'hFFFF_FFFF);
        rchk("status", IRQ_STATUS_ADDR, 32'h8000_0000);
        u_host_model.wr(IRQ_ENABLE_ADDR, 32'h0000_0000);
        pulse(28);
        pulse(29);
        u_host_model.wr(IRQ_STATUS_ADDR, 32'hFFFF_FFFF);
        irq_is(1'h0);
        rchk("status", IRQ_STATUS_ADDR, 32'hB000_0000);
        @(posedge sys_clk);
        #1 sw_reset = 1'h1;
        @(posedge sys_clk);
        #1 sw_reset = 1'h0;
        irq_is(1'h1);
        rchk("status", IRQ_STATUS_ADDR, 32'h0000_0000);
        pulse(28);
        irq_is(1'h0);
        #1 rst_n = 1'h0;
        repeat (2) @(posedge sys_clk);
        #1 rst_n = 1'h1;
        irq_is(1'h1);
        rchk("status", IRQ_STATUS_ADDR, 32'h0000_0000);
    endtask : s_faults

    initial begin
        repeat (20000) @(posedge sys_clk);
        bad_count++;
        end_sim();
    end

    initial begin
        rst_n = 1'h0;
        sw_reset = 1'h0;
        ev = '0;
        bad_count = 0;
        samples_checked = 0;
        repeat (8) @(posedge sys_clk);
        #1 rst_n = 1'h1;
        s_reset_map();
        s_sources();
        s_refused();
        s_faults();
        end_sim();
    end
endmodule : test_power_monitor_irq_mask
